// *** src/fifo_pkg.sv ***
`default_nettype none
package fifo_pkg;
  localparam int DATA_W = 18;
  localparam int DEPTH  = 131072;
  localparam int OFS_W  = 14;
  // Preset offsets indexed by {load select, select0, select1}
  localparam logic [OFS_W-1:0] OFS_000 = 14'h007F;
  localparam logic [OFS_W-1:0] OFS_001 = 14'h3FFF;
  localparam logic [OFS_W-1:0] OFS_010 = 14'h1FFF;
  localparam logic [OFS_W-1:0] OFS_011 = 14'h0FFF;
  localparam logic [OFS_W-1:0] OFS_100 = 14'h03FF;
  localparam logic [OFS_W-1:0] OFS_101 = 14'h07FF;
  localparam logic [OFS_W-1:0] OFS_110 = 14'h01FF;
  localparam logic [OFS_W-1:0] OFS_111 = 14'h00FF;
  // APB register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_MRS  = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_LD_N = 2;
  localparam int CTRL_SEL0 = 3;
  localparam int CTRL_SEL1 = 4;
  localparam int CTRL_W    = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h05;
  localparam int ST_EMPTY_N  = 0;
  localparam int ST_FULL_N   = 1;
  localparam int ST_AEMPTY_N = 2;
  localparam int ST_AFULL_N  = 3;
  localparam int ST_HALF_N   = 4;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_PULSE = 2'b01,
    H_WAIT  = 2'b10,
    H_DONE  = 2'b11
  } host_state_type;
endpackage
`default_nettype wire

// *** src/fifo_link_if.sv ***
`default_nettype none
interface fifo_link_if #(parameter int DATA_W = fifo_pkg::DATA_W);
  logic              mrs_n;
  logic              timing_mode_serial_in;
  logic              offset_load_select_n;
  logic              preset_offset_select0;
  logic              preset_offset_select1;
  logic              write_en_n;
  logic [DATA_W-1:0] data_in;
  logic              read_en_n;
  logic [DATA_W-1:0] data_out;
  logic              empty_indicator_n;
  logic              full_indicator_n;
  logic              almost_empty_n;
  logic              almost_full_n;
  logic              half_full_n;
  modport dev (
    input  mrs_n, timing_mode_serial_in, offset_load_select_n,
    input  preset_offset_select0, preset_offset_select1,
    input  write_en_n, data_in, read_en_n,
    output data_out, empty_indicator_n, full_indicator_n,
    output almost_empty_n, almost_full_n, half_full_n
  );
  modport host (
    output mrs_n, timing_mode_serial_in, offset_load_select_n,
    output preset_offset_select0, preset_offset_select1,
    output write_en_n, data_in, read_en_n,
    input  data_out, empty_indicator_n, full_indicator_n,
    input  almost_empty_n, almost_full_n, half_full_n
  );
endinterface
`default_nettype wire

// *** src/fifo_device.sv ***
`default_nettype none
module fifo_device #(
  parameter int DATA_W = fifo_pkg::DATA_W,
  parameter int DEPTH  = fifo_pkg::DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  fifo_link_if.dev link
);
  localparam int AW    = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 2);
  localparam int TW    = ((CNT_W > fifo_pkg::OFS_W) ? CNT_W : fifo_pkg::OFS_W) + 2;
  localparam logic [CNT_W-1:0] D_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] D_HALF = CNT_W'(DEPTH / 2);

  logic [DATA_W-1:0] mem [DEPTH];
  logic              fall_through_timing_r;
  logic [fifo_pkg::OFS_W-1:0] ofs_r;
  logic [AW-1:0]     wptr_r;
  logic [AW-1:0]     rptr_r;
  logic [CNT_W-1:0]  wcnt_r;
  logic [CNT_W-1:0]  rcnt_r;
  logic              wr_d1_r;
  logic              wr_d2_r;
  logic              rd_d1_r;
  logic              rd_d2_r;
  logic              ov_r;
  logic              ov_nxt;
  logic              empty_s1_r;
  logic              empty_s2_r;
  logic              full_s1_r;
  logic [DATA_W-1:0] dout_r;
  logic              empty_pin_r;
  logic              full_pin_r;
  logic              aempty_r;
  logic              afull_r;
  logic              half_r;
  logic              run;
  logic [CNT_W-1:0]  limit;
  logic [TW-1:0]     ofs_ext;
  logic [CNT_W-1:0]  fw_ext;
  logic [CNT_W-1:0]  rtotal;
  logic              wr_go;
  logic              std_rd;
  logic              fw_take;
  logic              fetch;
  logic              leave;

  assign run     = link.mrs_n;
  assign fw_ext  = CNT_W'(fall_through_timing_r);
  assign ofs_ext = TW'(ofs_r);
  // Output register adds one word of capacity in fall-through timing
  assign limit   = D_CNT + fw_ext;
  assign wr_go   = run && !link.write_en_n && (wcnt_r != limit);
  assign std_rd  = run && !fall_through_timing_r && !link.read_en_n && (rcnt_r != '0);
  assign fw_take = run && fall_through_timing_r && !link.read_en_n && ov_r;
  // Fall-through refills the output slot with no request
  assign fetch   = std_rd || (run && fall_through_timing_r && (rcnt_r != '0) && (!ov_r || fw_take));
  assign leave   = std_rd || fw_take;
  assign rtotal  = rcnt_r + CNT_W'(fall_through_timing_r && ov_r);

  always_comb
  begin
    ov_nxt = ov_r;
    if (!run)
    begin
      ov_nxt = 1'b0;
    end
    else if (fall_through_timing_r && fetch)
    begin
      ov_nxt = 1'b1;
    end
    else if (fw_take)
    begin
      ov_nxt = 1'b0;
    end
  end

  // Mode follows the pin for as long as master reset is held
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fall_through_timing_r <= 1'b0;
    else if (!run)
      fall_through_timing_r <= link.timing_mode_serial_in;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ofs_r <= fifo_pkg::OFS_000;
    else if (!run)
    begin
      case ({link.offset_load_select_n, link.preset_offset_select0,
             link.preset_offset_select1})
        3'b000:  ofs_r <= fifo_pkg::OFS_000;
        3'b001:  ofs_r <= fifo_pkg::OFS_001;
        3'b010:  ofs_r <= fifo_pkg::OFS_010;
        3'b011:  ofs_r <= fifo_pkg::OFS_011;
        3'b100:  ofs_r <= fifo_pkg::OFS_100;
        3'b101:  ofs_r <= fifo_pkg::OFS_101;
        3'b110:  ofs_r <= fifo_pkg::OFS_110;
        3'b111:  ofs_r <= fifo_pkg::OFS_111;
        default: ofs_r <= fifo_pkg::OFS_000;
      endcase
    end
  end

  // Storage has no reset, so it maps onto block memory
  always_ff @(posedge mclk)
  begin
    if (wr_go)
      mem[wptr_r] <= link.data_in;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wptr_r <= '0;
    else if (!run)
      wptr_r <= '0;
    else if (wr_go)
      wptr_r <= AW'(wptr_r + 1'b1);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rptr_r <= '0;
    else if (!run)
      rptr_r <= '0;
    else if (fetch)
      rptr_r <= AW'(rptr_r + 1'b1);
  end

  // Events cross between write and read sides through two stages,
  // so each side sees the other late but never optimistic
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_d1_r <= 1'b0;
      wr_d2_r <= 1'b0;
      rd_d1_r <= 1'b0;
      rd_d2_r <= 1'b0;
    end
    else if (!run)
    begin
      wr_d1_r <= 1'b0;
      wr_d2_r <= 1'b0;
      rd_d1_r <= 1'b0;
      rd_d2_r <= 1'b0;
    end
    else
    begin
      wr_d1_r <= wr_go;
      wr_d2_r <= wr_d1_r;
      rd_d1_r <= leave;
      rd_d2_r <= rd_d1_r;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wcnt_r <= '0;
    else if (!run)
      wcnt_r <= '0;
    else
      wcnt_r <= wcnt_r + CNT_W'(wr_go) - CNT_W'(rd_d2_r);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rcnt_r <= '0;
    else if (!run)
      rcnt_r <= '0;
    else
      rcnt_r <= rcnt_r + CNT_W'(wr_d2_r) - CNT_W'(fetch);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ov_r <= 1'b0;
    else
      ov_r <= ov_nxt;
  end

  // Outputs hold the last word when a read is refused
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      dout_r <= '0;
    else if (fetch)
      dout_r <= mem[rptr_r];
  end

  // Two stages ahead of the empty pin in standard timing, one stage ahead of the full pin
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      empty_s1_r <= 1'b0;
      empty_s2_r <= 1'b0;
      full_s1_r  <= 1'b1;
    end
    else
    begin
      empty_s1_r <= (rcnt_r != '0);
      empty_s2_r <= empty_s1_r;
      full_s1_r  <= (wcnt_r != limit);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      empty_pin_r <= 1'b0;
      full_pin_r  <= 1'b1;
    end
    else if (fall_through_timing_r)
    begin
      empty_pin_r <= !ov_nxt;
      full_pin_r  <= !full_s1_r;
    end
    else
    begin
      empty_pin_r <= empty_s2_r;
      full_pin_r  <= full_s1_r;
    end
  end

  // Thresholds shift by one word in fall-through timing
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      aempty_r <= 1'b0;
      half_r   <= 1'b1;
      afull_r  <= 1'b1;
    end
    else
    begin
      // Wide sums: an offset above the depth never wraps almost-empty, but D_CNT - ofs_ext wraps and holds almost-full off
      aempty_r <= (TW'(rtotal) >= ofs_ext + TW'(fw_ext) + TW'(1));
      half_r   <= !(TW'(wcnt_r) >= TW'(D_HALF) + TW'(fw_ext) + TW'(1));
      afull_r  <= !(TW'(wcnt_r) >= TW'(D_CNT) - ofs_ext + TW'(fw_ext));
    end
  end

  assign link.data_out          = dout_r;
  assign link.empty_indicator_n = empty_pin_r;
  assign link.full_indicator_n  = full_pin_r;
  assign link.almost_empty_n    = aempty_r;
  assign link.almost_full_n     = afull_r;
  assign link.half_full_n       = half_r;
endmodule
`default_nettype wire

// *** src/fifo_host.sv ***
`default_nettype none
module fifo_host #(
  parameter int DATA_W = fifo_pkg::DATA_W
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  fifo_link_if.host        link
);
  fifo_pkg::host_state_type state_r;
  logic [fifo_pkg::CTRL_W-1:0] ctrl_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       prdata_r;
  logic              wen_n_r;
  logic              ren_n_r;
  logic [DATA_W-1:0] din_r;
  logic              access;
  logic              mapped;
  logic [31:0]       rd_val;

  assign access = psel && penable && !pready_r;
  assign mapped = (paddr == fifo_pkg::REG_CTRL) || (paddr == fifo_pkg::REG_WDATA)
               || (paddr == fifo_pkg::REG_RDATA) || (paddr == fifo_pkg::REG_STATUS);

  always_comb
  begin
    rd_val = '0;
    if (paddr == fifo_pkg::REG_CTRL)
      rd_val = 32'(ctrl_r);
    else if (paddr == fifo_pkg::REG_STATUS)
    begin
      rd_val[fifo_pkg::ST_EMPTY_N]  = link.empty_indicator_n;
      rd_val[fifo_pkg::ST_FULL_N]   = link.full_indicator_n;
      rd_val[fifo_pkg::ST_AEMPTY_N] = link.almost_empty_n;
      rd_val[fifo_pkg::ST_AFULL_N]  = link.almost_full_n;
      rd_val[fifo_pkg::ST_HALF_N]   = link.half_full_n;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r   <= fifo_pkg::H_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      ren_n_r   <= 1'b1;
    end
    else
    begin
      case (state_r)
        fifo_pkg::H_IDLE:
        begin
          if (access && !pwrite && (paddr == fifo_pkg::REG_RDATA))
          begin
            // Fall-through already shows the word; the pulse only advances
            prdata_r <= 32'(link.data_out);
            ren_n_r  <= 1'b0;
            state_r  <= fifo_pkg::H_PULSE;
          end
          else if (access)
          begin
            prdata_r  <= pwrite ? 32'h0 : rd_val;
            pslverr_r <= !mapped;
            pready_r  <= 1'b1;
            state_r   <= fifo_pkg::H_DONE;
          end
        end
        fifo_pkg::H_PULSE:
        begin
          ren_n_r <= 1'b1;
          state_r <= fifo_pkg::H_WAIT;
        end
        fifo_pkg::H_WAIT:
        begin
          if (!ctrl_r[fifo_pkg::CTRL_MODE])
            prdata_r <= 32'(link.data_out);
          pslverr_r <= 1'b0;
          pready_r  <= 1'b1;
          state_r   <= fifo_pkg::H_DONE;
        end
        fifo_pkg::H_DONE:
        begin
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          state_r   <= fifo_pkg::H_IDLE;
        end
        default: state_r <= fifo_pkg::H_IDLE;
      endcase
    end
  end

  // Writes take effect at the edge that completes the transfer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r  <= fifo_pkg::CTRL_RESET;
      wen_n_r <= 1'b1;
      din_r   <= '0;
    end
    else
    begin
      wen_n_r <= 1'b1;
      if ((state_r == fifo_pkg::H_DONE) && psel && penable && pwrite)
      begin
        if (paddr == fifo_pkg::REG_CTRL)
          ctrl_r <= pwdata[fifo_pkg::CTRL_W-1:0];
        else if (paddr == fifo_pkg::REG_WDATA)
        begin
          din_r   <= pwdata[DATA_W-1:0];
          wen_n_r <= 1'b0;
        end
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign link.mrs_n                 = !ctrl_r[fifo_pkg::CTRL_MRS];
  assign link.timing_mode_serial_in = ctrl_r[fifo_pkg::CTRL_MODE];
  assign link.offset_load_select_n  = ctrl_r[fifo_pkg::CTRL_LD_N];
  assign link.preset_offset_select0 = ctrl_r[fifo_pkg::CTRL_SEL0];
  assign link.preset_offset_select1 = ctrl_r[fifo_pkg::CTRL_SEL1];
  assign link.write_en_n = wen_n_r;
  assign link.read_en_n  = ren_n_r;
  assign link.data_in    = din_r;
endmodule
`default_nettype wire

// *** verif/fifo_link_props.sv ***
`default_nettype none
module fifo_link_props #(
  parameter int DATA_W = fifo_pkg::DATA_W
) (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              mrs_n,
  input wire logic              timing_mode_serial_in,
  input wire logic              write_en_n,
  input wire logic              read_en_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              empty_indicator_n,
  input wire logic              full_indicator_n,
  input wire logic              almost_empty_n,
  input wire logic              almost_full_n,
  input wire logic              half_full_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       mode_r;
  logic [3:0] run_r;
  logic [3:0] idle_r;
  logic       std;
  logic       ft;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Own copy of the latched mode, so checks other than a_mrs_clear_flags never follow the live pin
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode_r <= 1'b0;
    else if (!mrs_n)
      mode_r <= timing_mode_serial_in;
  end
  // Flags need a few edges to settle after master reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      run_r <= 4'h0;
    else if (!mrs_n)
      run_r <= 4'h0;
    else if (run_r != 4'hF)
      run_r <= run_r + 4'h1;
  end
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      idle_r <= 4'h0;
    else if (!write_en_n)
      idle_r <= 4'h0;
    else if (idle_r != 4'hF)
      idle_r <= idle_r + 4'h1;
  end
  assign std = !mode_r && (run_r >= 4'h4);
  assign ft  = mode_r && (run_r >= 4'h4);
  a_mrs_clear_flags: assert property ((!mrs_n && !timing_mode_serial_in) [*5] |->
    full_indicator_n && half_full_n && almost_full_n && !almost_empty_n && !empty_indicator_n)
    else $error("flags not cleared by master reset");
  a_empty_rise_std: assert property (std && !write_en_n && !empty_indicator_n
    |-> ##[1:6] empty_indicator_n) else $error("empty indicator late after first write");
  a_ft_first_word: assert property (ft && !write_en_n && empty_indicator_n
    |-> ##[1:4] !empty_indicator_n) else $error("first word did not fall through in time");
  a_full_has_flags: assert property (std && !full_indicator_n
    |-> !almost_full_n && !half_full_n) else $error("full without almost-full and half-full");
  a_empty_has_ae: assert property (std && !empty_indicator_n
    |-> !almost_empty_n) else $error("empty without almost-empty");
  a_empty_read_ignored: assert property (std && !read_en_n && !empty_indicator_n
    && idle_r >= 4'h6 |=> $stable(data_out) ##1 $stable(data_out))
    else $error("read while empty changed the outputs");
  a_data_needs_read: assert property (std && read_en_n && $past(read_en_n)
    && $past(read_en_n, 2) |-> $stable(data_out)) else $error("data changed without a read");
  a_ft_input_space: assert property (ft && half_full_n |-> !full_indicator_n)
    else $error("no input space shown below half full");
endmodule
`default_nettype wire

// *** verif/dual_clock_fifo_flag_control_tb.sv ***
`default_nettype none
module dual_clock_fifo_flag_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D     = 512;
  localparam int N_OFS = 255;
  localparam int LIMIT = 40000;
  logic        mclk    = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  logic [31:0] w;
  logic [31:0] q[$];
  int          seed        = 32'h34F21BD6;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  fifo_link_if link ();
  fifo_device #(.DATA_W(fifo_pkg::DATA_W), .DEPTH(D)) fifo_device_i (.mclk(mclk),
    .rstn(rstn), .link(link));
  fifo_host #(.DATA_W(fifo_pkg::DATA_W)) fifo_host_i (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  fifo_link_props #(.DATA_W(fifo_pkg::DATA_W)) fifo_link_props_i (.mclk(mclk), .rstn(rstn),
    .mrs_n(link.mrs_n), .timing_mode_serial_in(link.timing_mode_serial_in),
    .write_en_n(link.write_en_n), .read_en_n(link.read_en_n), .data_out(link.data_out),
    .empty_indicator_n(link.empty_indicator_n), .full_indicator_n(link.full_indicator_n),
    .almost_empty_n(link.almost_empty_n), .almost_full_n(link.almost_full_n),
    .half_full_n(link.half_full_n));
  always #25 mclk = ~mclk;
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Entered just after a rising edge; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge mclk);
    end
    if (k == 20)
      n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] st_exp(input int c);
    logic [31:0] s;
    s = 32'h0;
    s[fifo_pkg::ST_EMPTY_N] = (c > 0);
    s[fifo_pkg::ST_FULL_N] = (c < D);
    s[fifo_pkg::ST_AEMPTY_N] = (c >= N_OFS + 1);
    s[fifo_pkg::ST_AFULL_N] = (c < D - N_OFS);
    s[fifo_pkg::ST_HALF_N] = (c < D / 2 + 1);
    return s;
  endfunction
  // Flags cross two stages, so let them settle before looking
  task automatic chk_st(input int c);
    repeat (8) @(posedge mclk);
    apb(1'b0, fifo_pkg::REG_STATUS, 32'h0, rd, err);
    chk("status", rd & 32'h1F, st_exp(c));
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk_st(0);
    apb(1'b0, fifo_pkg::REG_CTRL, 32'h0, rd, err);
    chk("ctrl", rd & 32'h1F, 32'h05);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h1D, rd, err);
    repeat (4) @(posedge mclk);
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h1C, rd, err);
    chk_st(0);
    apb(1'b0, fifo_pkg::REG_RDATA, 32'h0, rd, err);
    chk_st(0);
    for (int i = 0; i <= D; i++)
    begin
      w = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
      apb(1'b1, fifo_pkg::REG_WDATA, w, rd, err);
      if (i < D)
        q.push_back(w & 32'h3FFFF);
      chk_st(q.size());
    end
    while (q.size() > 0)
    begin
      apb(1'b0, fifo_pkg::REG_RDATA, 32'h0, rd, err);
      chk("rdata", rd & 32'h3FFFF, q[0]);
      w = q.pop_front();
      chk_st(q.size());
    end
    apb(1'b0, fifo_pkg::REG_RDATA, 32'h0, rd, err);
    chk("rdata_empty", rd & 32'h3FFFF, w);
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h1F, rd, err);
    repeat (4) @(posedge mclk);
    // Mode pin drops with the release: the latched mode must hold
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h1C, rd, err);
    repeat (8) @(posedge mclk);
    apb(1'b1, fifo_pkg::REG_WDATA, 32'h2A5A5, rd, err);
    repeat (8) @(posedge mclk);
    chk("ft_data", 32'(link.data_out), 32'h2A5A5);
    chk("ft_ready", 32'(link.empty_indicator_n), 32'h0);
    apb(1'b0, fifo_pkg::REG_RDATA, 32'h0, rd, err);
    chk("ft_rdata", rd & 32'h3FFFF, 32'h2A5A5);
    repeat (8) @(posedge mclk);
    chk("ft_drained", 32'(link.empty_indicator_n), 32'h1);
    chk("ft_space", 32'(link.full_indicator_n), 32'h0);
    // Smallest preset offset, standard timing: almost-empty rises at n+1
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h01, rd, err);
    repeat (4) @(posedge mclk);
    apb(1'b1, fifo_pkg::REG_CTRL, 32'h00, rd, err);
    repeat (8) @(posedge mclk);
    for (int i = 1; i <= 128; i++)
    begin
      apb(1'b1, fifo_pkg::REG_WDATA, $random(seed), rd, err);
      if (i >= 127)
      begin
        repeat (8) @(posedge mclk);
        apb(1'b0, fifo_pkg::REG_STATUS, 32'h0, rd, err);
        chk("ae_preset", 32'(rd[fifo_pkg::ST_AEMPTY_N]), 32'(i >= 128));
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
